// >>> rbl_reset_boot.sv
/*
 * Chip reset sequencer and boot-mode latch: holds the chip in reset, latches the
 * operating mode on release, and frees the internal reset after a fixed count.
 * Assumes rst is the power-on reset, all pins are synchronous to ref_clk (50 MHz).
 */
// Contract
// - External reset low keeps all logic except the debug module in reset.
// - On external reset release, latch the boot pin as operating mode.
// - Release internal reset synchronously after a fixed cycle count.
// - Reset output pin always mirrors the internal reset state.
// - Power-on reset asserts the chip reset without any external reset.
// - Boot pin high requests external boot, honoured only when flash unsecured.
// - Chip reset alone leaves the debug module unreset; full reset needs both.
// - Secured flash forces internal boot, both mode bits zero.
// - Secured-state bit loads only at reset; later changes are ignored.
`timescale 1ns/100ps
`default_nettype none
`include "rbl_regs.svh"

module rbl_reset_boot
    import rbl_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic ext_reset_n,
    input  wire logic external_boot_select,
    input  wire logic ext_memory_addr_mode,
    input  wire logic flash_secured,
    input  wire logic jtag_trst_n,
    input  wire logic map_select_wr,
    input  wire logic map_select_wdata,
    output logic      chip_reset,
    output logic      reset_state_output_n,
    output logic      program_map_select,
    output logic      secured_state_flag,
    output logic      ext_addr_20bit,
    output logic      debug_reset
);
    import rbl_pkg::*;

    rbl_state_e state_reg;
    rbl_state_e state_next;
    logic       chip_rst_reg;
    logic       chip_rst_next;
    logic       pin_n_reg;
    logic       pin_n_next;
    logic       ma_reg;
    logic       ma_next;
    logic       mb_reg;
    logic       mb_next;
    logic       emi_reg;
    logic       emi_next;
    logic       dbg_reg;
    logic       dbg_next;
    logic       latch_now;
    logic       cnt_last;
    rbl_cnt_t   cnt_value;

    // Latch happens on the first cycle the external reset is seen released
    assign latch_now = (state_reg == RBL_ST_HOLD) && ext_reset_n;

    rbl_release_counter u_release
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clear   (state_reg != RBL_ST_COUNT),
        .enable  (state_reg == RBL_ST_COUNT),
        .count   (cnt_value),
        .last    (cnt_last)
    );

    always_comb
    begin
        state_next    = state_reg;
        chip_rst_next = chip_rst_reg;
        ma_next       = ma_reg;
        mb_next       = mb_reg;
        emi_next      = emi_reg;
        unique case (state_reg)
            RBL_ST_HOLD:
            begin
                chip_rst_next = 1'b1;
                if (ext_reset_n)
                begin
                    // Secured flash refuses external boot and falls back to mode 0
                    mb_next    = ~flash_secured;
                    ma_next    = external_boot_select & ~flash_secured;
                    emi_next   = ext_memory_addr_mode & external_boot_select
                                 & ~flash_secured;
                    state_next = RBL_ST_COUNT;
                end
            end
            RBL_ST_COUNT:
            begin
                if (!ext_reset_n)
                    state_next = RBL_ST_HOLD;
                else if (cnt_last)
                begin
                    state_next    = RBL_ST_RUN;
                    chip_rst_next = 1'b0;
                end
            end
            RBL_ST_RUN:
            begin
                if (!ext_reset_n)
                begin
                    state_next    = RBL_ST_HOLD;
                    chip_rst_next = 1'b1;
                end
                else if (map_select_wr && mb_reg)
                    ma_next = map_select_wdata;
            end
            default:
            begin
                state_next    = RBL_ST_HOLD;
                chip_rst_next = 1'b1;
            end
        endcase
        // Pin follows the next reset value so it lines up with chip_reset
        pin_n_next = ~chip_rst_next;
        // Debug reset follows only its own line, never the chip reset
        dbg_next   = ~jtag_trst_n;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg    <= RBL_ST_HOLD;
            chip_rst_reg <= `RBL_CHIP_RST_VAL;
            pin_n_reg    <= `RBL_PIN_RST_VAL;
            ma_reg       <= `RBL_MA_RST_VAL;
            mb_reg       <= `RBL_MB_RST_VAL;
            emi_reg      <= `RBL_EMI_RST_VAL;
            dbg_reg      <= `RBL_DBG_RST_VAL;
        end
        else
        begin
            state_reg    <= state_next;
            chip_rst_reg <= chip_rst_next;
            pin_n_reg    <= pin_n_next;
            ma_reg       <= ma_next;
            mb_reg       <= mb_next;
            emi_reg      <= emi_next;
            dbg_reg      <= dbg_next;
        end
    end

    assign chip_reset           = chip_rst_reg;
    assign reset_state_output_n = pin_n_reg;
    assign program_map_select   = ma_reg;
    assign secured_state_flag   = mb_reg;
    assign ext_addr_20bit       = emi_reg;
    assign debug_reset          = dbg_reg;

    a_ext_low_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !ext_reset_n |=> chip_rst_reg)
        else $error("chip reset not held while external reset low");

    a_mode_latch: assert property (@(posedge ref_clk) disable iff (rst)
        latch_now |=> ma_reg == $past(external_boot_select & ~flash_secured))
        else $error("boot mode not latched at release");

    a_release_wait: assert property (@(posedge ref_clk) disable iff (rst)
        latch_now |=> chip_rst_reg[*8])
        else $error("internal reset released too early");

    a_release_count: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(chip_rst_reg) |-> $past(cnt_value) == `RBL_RELEASE_LAST)
        else $error("internal reset released off count");

    a_pin_mirror: assert property (@(posedge ref_clk) disable iff (rst)
        pin_n_reg == ~chip_rst_reg)
        else $error("reset pin does not mirror internal reset");

    a_por_start: assert property (@(posedge ref_clk) disable iff (rst)
        $past(rst) |-> chip_rst_reg && (state_reg != RBL_ST_RUN))
        else $error("power-on reset not in effect");

    a_secure_boot: assert property (@(posedge ref_clk) disable iff (rst)
        !mb_reg |-> !ma_reg && !emi_reg)
        else $error("external boot taken with secured flash");

    a_mb_frozen: assert property (@(posedge ref_clk) disable iff (rst)
        !latch_now |=> $stable(mb_reg))
        else $error("secured-state bit changed outside reset");

    a_debug_apart: assert property (@(posedge ref_clk) disable iff (rst)
        chip_rst_reg && jtag_trst_n |=> !dbg_reg)
        else $error("debug module reset by chip reset alone");

    c_release: cover property (@(posedge ref_clk) disable iff (rst) $fell(chip_rst_reg));
    c_ext_boot: cover property (@(posedge ref_clk) disable iff (rst)
        latch_now && external_boot_select && !flash_secured);
    c_secured: cover property (@(posedge ref_clk) disable iff (rst)
        latch_now && external_boot_select && flash_secured);
    c_abort: cover property (@(posedge ref_clk) disable iff (rst)
        state_reg == RBL_ST_COUNT && !ext_reset_n);
endmodule

`default_nettype wire

// >>> rbl_regs.svh
/*
 * Named constants for the reset and boot-mode latch: release count and reset values.
 * Assumes it is included by bare name from the package and the design modules.
 */
`ifndef RBL_REGS_SVH
`define RBL_REGS_SVH

`define RBL_CNT_W          6
`define RBL_CNT_ZERO       6'h00
`define RBL_CNT_ONE        6'h01
`define RBL_RELEASE_LAST   6'h1f
`define RBL_CHIP_RST_VAL   1'b1
`define RBL_PIN_RST_VAL    1'b0
`define RBL_MA_RST_VAL     1'b0
`define RBL_MB_RST_VAL     1'b0
`define RBL_EMI_RST_VAL    1'b0
`define RBL_DBG_RST_VAL    1'b1

`endif

// >>> rbl_pkg.sv
/*
 * Types shared by the reset and boot-mode latch modules.
 * Assumes rbl_regs.svh is on the include path.
 */
`include "rbl_regs.svh"

package rbl_pkg;
    typedef enum logic [1:0]
    {
        RBL_ST_HOLD  = 2'b00,
        RBL_ST_COUNT = 2'b01,
        RBL_ST_RUN   = 2'b10
    } rbl_state_e;

    typedef logic [`RBL_CNT_W-1:0] rbl_cnt_t;
endpackage

// >>> rbl_release_counter.sv
/*
 * Release delay counter: counts enabled cycles from a clear, flags the last one.
 * Assumes a single clock ref_clk and asynchronous active-high rst.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rbl_regs.svh"

module rbl_release_counter
    import rbl_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          rst,
    input  wire logic          clear,
    input  wire logic          enable,
    output var  rbl_pkg::rbl_cnt_t count,
    output logic               last
);
    import rbl_pkg::*;

    rbl_cnt_t cnt_reg;
    rbl_cnt_t cnt_next;

    always_comb
    begin
        cnt_next = cnt_reg;
        if (clear)
            cnt_next = `RBL_CNT_ZERO;
        else if (enable && (cnt_reg != `RBL_RELEASE_LAST))
            cnt_next = cnt_reg + `RBL_CNT_ONE;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            cnt_reg <= `RBL_CNT_ZERO;
        else
            cnt_reg <= cnt_next;
    end

    assign count = cnt_reg;
    assign last  = (cnt_reg == `RBL_RELEASE_LAST);
endmodule

`default_nettype wire

// >>> rbl_board.sv
/* Board side model: reset supervisor, strap resistors and debug probe.
   Assumes the bench sets the wanted levels; straps are static resistors. */
`timescale 1ns/100ps
`default_nettype none
module rbl_board (
    input  wire logic hold_n,
    input  wire logic boot,
    input  wire logic emi,
    input  wire logic sec,
    input  wire logic trst_n,
    output logic      ext_reset_n,
    output logic      external_boot_select,
    output logic      ext_memory_addr_mode,
    output logic      flash_secured,
    output logic      jtag_trst_n
);
    // Tied high for off-chip boot, low for internal boot; driven hard, so the
    // pull-up that boot software turns off when strapped low never sets the level
    assign external_boot_select = boot;
    // Low unless the wide address bus is wanted
    assign ext_memory_addr_mode = emi;
    assign flash_secured = sec;
    assign ext_reset_n = hold_n;
    // Probe reset is kept apart from the chip reset
    assign jtag_trst_n = trst_n;
endmodule
`default_nettype wire

// >>> tb_top.sv
/* Testbench for the reset sequencer and boot-mode latch.
   Assumes the board model drives every strap and the external and probe reset pins; rst comes from the bench. */
`timescale 1ns/100ps
`default_nettype none
`include "rbl_regs.svh"
module tb_top;
    import rbl_pkg::*;
    logic ref_clk = 0, rst = 1, hold_n = 1, boot = 0, emi = 0, sec = 0, trst_n = 1;
    logic wr = 0, wd = 0, cr, rso_n, ma, mb, a20, dr;
    wire logic ern, ebs, ema, fsec, jtn;
    int mismatches = 0, tests_run = 0;
    always #10 ref_clk = ~ref_clk;
    rbl_board board (.hold_n(hold_n), .boot(boot), .emi(emi), .sec(sec), .trst_n(trst_n),
        .ext_reset_n(ern), .external_boot_select(ebs), .ext_memory_addr_mode(ema),
        .flash_secured(fsec), .jtag_trst_n(jtn));
    rbl_reset_boot dut (.ref_clk(ref_clk), .rst(rst), .ext_reset_n(ern),
        .external_boot_select(ebs), .ext_memory_addr_mode(ema), .flash_secured(fsec),
        .jtag_trst_n(jtn), .map_select_wr(wr), .map_select_wdata(wd), .chip_reset(cr),
        .reset_state_output_n(rso_n), .program_map_select(ma), .secured_state_flag(mb),
        .ext_addr_20bit(a20), .debug_reset(dr));
    task automatic check(input logic seen, input logic exp, input string msg);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic final_report;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Chip reset, then release with the given straps and count to the release
    task automatic boot_seq(input logic b, input logic e, input logic s);
        int n;
        @(posedge ref_clk);
        hold_n <= 0;
        boot <= b;
        emi <= e;
        sec <= s;
        repeat (3) @(posedge ref_clk);
        #1;
        check(cr, 1'b1, "held");
        check(rso_n, 1'b0, "pin in reset");
        check(dr, 1'b0, "debug left alone");
        @(posedge ref_clk);
        hold_n <= 1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (cr !== 1'b0 && n < 60);
        // One edge to latch, the full count, one edge to register the release
        check(n == (`RBL_RELEASE_LAST + 2), 1'b1, "release count");
        check(rso_n, 1'b1, "pin released");
        check(ma, b & ~s, "map bit");
        check(mb, ~s, "secured flag");
        check(a20, e & b & ~s, "wide bus");
        // Security change after the latch must not reach the flag
        @(posedge ref_clk);
        sec <= ~s;
        repeat (2) @(posedge ref_clk);
        #1;
        check(mb, ~s, "flag frozen");
    endtask
    task automatic restart;
        @(posedge ref_clk);
        hold_n <= 0;
        @(posedge ref_clk);
        hold_n <= 1;
        repeat (20) @(posedge ref_clk);
        hold_n <= 0;
        @(posedge ref_clk);
        hold_n <= 1;
        repeat (`RBL_RELEASE_LAST + 1) @(posedge ref_clk);
        #1;
        check(cr, 1'b1, "count restarted");
        @(posedge ref_clk);
        #1;
        check(cr, 1'b0, "released");
    endtask
    task automatic dbg;
        @(posedge ref_clk);
        trst_n <= 0;
        @(posedge ref_clk);
        #1;
        check(dr, 1'b1, "debug reset");
        check(cr, 1'b0, "chip runs");
        @(posedge ref_clk);
        trst_n <= 1;
    endtask
    task automatic map_wr(input logic d, input logic exp);
        @(posedge ref_clk);
        wr <= 1;
        wd <= d;
        @(posedge ref_clk);
        wr <= 0;
        #1;
        check(ma, exp, "map write");
    endtask
    initial
    begin
        repeat (5) @(posedge ref_clk);
        #1;
        check(cr, 1'b1, "power on reset");
        repeat (5) @(posedge ref_clk);
        rst <= 0;
        for (int i = 0; i < 8; i++)
            boot_seq(i[0], i[1], i[2]);
        map_wr(1'b1, 1'b0);
        boot_seq(1'b1, 1'b0, 1'b0);
        map_wr(1'b0, 1'b0);
        map_wr(1'b1, 1'b1);
        restart;
        dbg;
        final_report;
    end
    // Whole run is about 444 cycles
    initial
    begin
        #100us;
        mismatches++;
        final_report;
    end
endmodule
`default_nettype wire
